// [logic/dacc_control.sv]
// Purpose: Control of two ladder converters, one buffered with pin routing and ranging
// Assumes: Single 50 MHz clock, rst is the device reset, sleep comes from the same clock
// Notes: Registers sit at their printed offsets on a plain strobe port
//
// Summary of operation
// - Converter runs only while its enable bit is set.
// - Code selects one of 2^n ladder levels between the two references.
// - Upper and lower references are selected independently per converter.
// - Range choice applies only to the first converter's buffered output.
// - A configuration bit picks software ranging or automatic ranging.
// - Configuration bit one takes range from the software range bit.
// - Software range bit one selects the high range.
// - Software range bit zero selects the low range.
// - Configuration bit zero derives range from the live code value.
// - Wake from sleep or watchdog wake leaves registers untouched.
// - Reference is switched off during sleep.
// - Device reset clears the enable bit.
// - Device reset disconnects the output from all pins.
// - Device reset clears the code to zero.
// - First converter's buffer can be routed to its output pins.
// - Second converter has no pins or buffer, internal use only.
// - Pin field 01 selects pin one, 10 pin two, else none.
// - Upper select 00..11 supply, ext, fixed buf two, amp; lower ground or ext.
//
// Chosen here: strobed register access and the address map.
`include "dacc_cfg.svh"

module dacc_control #(
	parameter int CODE_W = 8,
	parameter logic [7:0] AUTO_THRESH = `DACC_AUTO_THRESH
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sleep,
	input wire logic auto_range_cfg_n,
	input wire logic [`DACC_ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic conv1_en,
	output logic conv2_en,
	output logic ref1_en,
	output logic ref2_en,
	output logic [CODE_W-1:0] level_code1,
	output logic [CODE_W-1:0] level_code2,
	output dacc_pkg::dacc_upref_t upper_ref_select1,
	output dacc_pkg::dacc_loref_t lower_ref_select1,
	output dacc_pkg::dacc_upref_t upper_ref_select2,
	output dacc_pkg::dacc_loref_t lower_ref_select2,
	output dacc_pkg::dacc_range_t buffer_range_select,
	output logic buffer_en,
	output logic [1:0] buffered_out_pins
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (CODE_W < 1 || CODE_W > 8)
	begin : g_bad_width
		$error("dacc_control: CODE_W must be 1 to 8");
	end

	// ----------------------------------------------------------------
	// Configuration bit synchroniser
	// ----------------------------------------------------------------
	logic cfg_meta_q;
	logic cfg_sync_q;

	// Config word bit comes from the fuse domain, so it is resynchronised
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cfg_meta_q <= 1'b1;
			cfg_sync_q <= 1'b1;
		end
		else
		begin
			cfg_meta_q <= auto_range_cfg_n;
			cfg_sync_q <= cfg_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Register port decode
	// ----------------------------------------------------------------
	logic wr_ctrl1;
	logic wr_data1;
	logic wr_ctrl2;
	logic wr_data2;

	// One write strobe per register; unmapped writes fall through unused
	assign wr_ctrl1 = wr && addr == `DACC_OFS_CTRL1;
	assign wr_data1 = wr && addr == `DACC_OFS_DATA1;
	assign wr_ctrl2 = wr && addr == `DACC_OFS_CTRL2;
	assign wr_data2 = wr && addr == `DACC_OFS_DATA2;

	// ----------------------------------------------------------------
	// Converter instances
	// ----------------------------------------------------------------
	logic [7:0] ctrl1_q;
	logic [7:0] ctrl2_q;
	logic [CODE_W-1:0] data1_q;
	logic [CODE_W-1:0] data2_q;

	// First converter carries the buffer and pin fields
	dacc_channel #(
		.HAS_BUF(1'b1),
		.CODE_W(CODE_W)
	) u_conv1 (
		.clk(clk),
		.rst(rst),
		.sleep(sleep),
		.ctrl_wr(wr_ctrl1),
		.data_wr(wr_data1),
		.wdata(wdata),
		.ctrl_q(ctrl1_q),
		.data_q(data1_q),
		.tap_q(level_code1),
		.ref_en_q(ref1_en)
	);

	// Second converter feeds internal selectors only, so its pin bits stay zero
	dacc_channel #(
		.HAS_BUF(1'b0),
		.CODE_W(CODE_W)
	) u_conv2 (
		.clk(clk),
		.rst(rst),
		.sleep(sleep),
		.ctrl_wr(wr_ctrl2),
		.data_wr(wr_data2),
		.wdata(wdata),
		.ctrl_q(ctrl2_q),
		.data_q(data2_q),
		.tap_q(level_code2),
		.ref_en_q(ref2_en)
	);

	// ----------------------------------------------------------------
	// Enables and reference selection
	// ----------------------------------------------------------------
	// Straight from the control registers, which are flip-flops
	assign conv1_en = ctrl1_q[`DACC_BIT_EN];
	assign conv2_en = ctrl2_q[`DACC_BIT_EN];
	assign upper_ref_select1 = dacc_pkg::dacc_upref_t'(ctrl1_q[`DACC_UPSEL_HI:`DACC_UPSEL_LO]);
	assign lower_ref_select1 = dacc_pkg::dacc_loref_t'(ctrl1_q[`DACC_BIT_LOSEL]);
	assign upper_ref_select2 = dacc_pkg::dacc_upref_t'(ctrl2_q[`DACC_UPSEL_HI:`DACC_UPSEL_LO]);
	assign lower_ref_select2 = dacc_pkg::dacc_loref_t'(ctrl2_q[`DACC_BIT_LOSEL]);

	// ----------------------------------------------------------------
	// Buffer range for the first converter
	// ----------------------------------------------------------------
	// Watches the code register itself so a new code retunes the buffer
	dacc_range #(
		.CODE_W(CODE_W),
		.THRESH(AUTO_THRESH)
	) u_range (
		.clk(clk),
		.rst(rst),
		.auto_range_cfg_n(cfg_sync_q),
		.soft_range(ctrl1_q[`DACC_BIT_RANGE]),
		.code(data1_q),
		.range_q(buffer_range_select)
	);

	// ----------------------------------------------------------------
	// Buffered output and pin routing
	// ----------------------------------------------------------------
	logic [1:0] pins_d;

	// Codes 00 and 11 both leave the pins floating, so only one pin at a time
	always_comb
	begin
		pins_d = 2'h0;
		if (ctrl1_q[`DACC_BIT_EN])
		begin
			unique case (ctrl1_q[`DACC_OE_HI:`DACC_OE_LO])
				`DACC_OE_PIN1: pins_d = 2'h1;
				`DACC_OE_PIN2: pins_d = 2'h2;
				default: pins_d = 2'h0;
			endcase
		end
	end

	// Pins released during sleep too, as the reference behind them is off
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			buffered_out_pins <= 2'h0;
			buffer_en <= 1'b0;
		end
		else
		begin
			buffered_out_pins <= sleep ? 2'h0 : pins_d;
			buffer_en <= ctrl1_q[`DACC_BIT_EN] & ~sleep;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Registered one cycle after the read strobe; unmapped offsets read zero
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rdata <= 8'h00;
		else if (rd)
		begin
			unique case (addr)
				`DACC_OFS_CTRL1: rdata <= ctrl1_q;
				`DACC_OFS_DATA1: rdata <= 8'(data1_q);
				`DACC_OFS_CTRL2: rdata <= ctrl2_q;
				`DACC_OFS_DATA2: rdata <= 8'(data2_q);
				default: rdata <= 8'h00;
			endcase
		end
		else
			rdata <= 8'h00;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Disabled converter parks its tap at zero
	tap_off_a: assert property (!conv1_en |=> level_code1 == '0)
		else $error("tap not parked while converter off");

	// Written code reaches the tap two clocks later while enabled
	tap_follow_a: assert property ((wr_data1 && conv1_en) ##1 conv1_en
		|=> level_code1 == $past(wdata[CODE_W-1:0], 2))
		else $error("tap did not follow written code");

	// Second converter's reference selects mirror its last control write
	ref_sel_a: assert property (wr_ctrl2
		|=> upper_ref_select2 == $past(wdata[`DACC_UPSEL_HI:`DACC_UPSEL_LO])
		&& lower_ref_select2 == $past(wdata[`DACC_BIT_LOSEL]))
		else $error("reference select does not match write");

	// Software ranging tracks the range bit
	soft_range_a: assert property (cfg_sync_q && $stable(cfg_sync_q)
		|=> buffer_range_select == $past(ctrl1_q[`DACC_BIT_RANGE]))
		else $error("software range not applied");

	// Automatic ranging ignores the range bit and follows the code
	auto_range_a: assert property (!cfg_sync_q
		|=> buffer_range_select == ($past(data1_q) >= AUTO_THRESH[7 -: CODE_W]))
		else $error("automatic range wrong");

	// Reference off through sleep, back one clock after waking while enabled
	ref_sleep_a: assert property (sleep |=> !ref1_en && !ref2_en)
		else $error("reference on during sleep");
	ref_wake_a: assert property ($fell(sleep) && conv1_en ##1 conv1_en
		|-> ##0 ref1_en)
		else $error("reference not restored after sleep");

	// Sleep never disturbs stored registers
	sleep_keep_a: assert property (sleep && !wr |=> $stable(ctrl1_q) && $stable(data1_q)
		&& $stable(ctrl2_q) && $stable(data2_q))
		else $error("registers changed during sleep");

	// Pin one and pin two never both driven, and only with a legal code
	pin_route_a: assert property (buffered_out_pins != 2'h3 && (buffered_out_pins == 2'h0
		|| $past(ctrl1_q[`DACC_OE_HI:`DACC_OE_LO]) == buffered_out_pins))
		else $error("illegal pin routing");

	// Second converter never exposes pin bits
	no_pins2_a: assert property (ctrl2_q[`DACC_OE_HI:`DACC_OE_LO] == 2'h0
		&& ctrl2_q[`DACC_BIT_RANGE] == 1'b0)
		else $error("second converter shows pin bits");

	// Read answer appears in the very next cycle
	read_back_a: assert property (rd && addr == `DACC_OFS_DATA2 |=> rdata == 8'($past(data2_q)))
		else $error("read data wrong");

	// At reset release both enables, the pins and both code registers are cleared
	rst_clear_a: assert property ($fell(rst) |-> !conv1_en && !conv2_en
		&& buffered_out_pins == 2'h0 && data1_q == '0 && data2_q == '0)
		else $error("reset state wrong");

	// Code register takes the byte present at the write edge
	code_store_a: assert property (wr_data1
		|=> data1_q == $past(wdata[CODE_W-1:0]))
		else $error("code write not stored");

	// Control writes keep only the bits the first converter owns
	ctrl_store_a: assert property (wr_ctrl1
		|=> ctrl1_q == ($past(wdata) & `DACC_MASK_BUF))
		else $error("first control write not stored");

	// Second control register drops the range and pin bits on write
	ctrl2_store_a: assert property (wr_ctrl2
		|=> ctrl2_q == ($past(wdata) & `DACC_MASK_NOBUF))
		else $error("second control write not stored");

	// First converter's reference selects follow its control write
	ref_sel1_a: assert property (wr_ctrl1
		|=> upper_ref_select1 == $past(wdata[`DACC_UPSEL_HI:`DACC_UPSEL_LO])
		&& lower_ref_select1 == $past(wdata[`DACC_BIT_LOSEL]))
		else $error("first reference select does not match write");

	// Disabled second converter parks its tap at zero
	tap2_off_a: assert property (!conv2_en
		|=> level_code2 == '0)
		else $error("second tap not parked while off");

	// Enabled and awake means reference and buffer powered next clock
	ref_on_a: assert property (conv1_en && !sleep
		|=> ref1_en && buffer_en)
		else $error("reference or buffer not powered");

	// Disabled or asleep, the buffer reaches no pin
	pins_off_a: assert property (!conv1_en || sleep
		|=> buffered_out_pins == 2'h0)
		else $error("pin driven while off or asleep");

	// Field 01 routes the buffer to pin one only
	pin_one_a: assert property (conv1_en && !sleep
		&& ctrl1_q[`DACC_OE_HI:`DACC_OE_LO] == `DACC_OE_PIN1
		|=> buffered_out_pins == 2'h1)
		else $error("pin one not selected");

	// Field 10 routes the buffer to pin two only
	pin_two_a: assert property (conv1_en && !sleep
		&& ctrl1_q[`DACC_OE_HI:`DACC_OE_LO] == `DACC_OE_PIN2
		|=> buffered_out_pins == 2'h2)
		else $error("pin two not selected");

	// Read port answers the first control register a cycle later
	read_ctrl_a: assert property (rd && addr == `DACC_OFS_CTRL1
		|=> rdata == $past(ctrl1_q))
		else $error("control read data wrong");

	// Read port answers the first code register a cycle later
	read_code_a: assert property (rd && addr == `DACC_OFS_DATA1
		|=> rdata == 8'($past(data1_q)))
		else $error("code read data wrong");

	// Read data falls back to zero when no read was strobed
	read_idle_a: assert property (!rd
		|=> rdata == 8'h00)
		else $error("read data not cleared");

endmodule : dacc_control

// [logic/dacc_cfg.svh]
// Purpose: Shared offsets, field positions, reset values and range threshold for the converter control
// Assumes: Included by bare name from every design file that needs it
// Notes: Definitions only
`ifndef DACC_CFG_SVH
`define DACC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DACC_ADDR_W 12
`define DACC_OFS_CTRL1 12'h88C
`define DACC_OFS_DATA1 12'h88D
`define DACC_OFS_CTRL2 12'h890
`define DACC_OFS_DATA2 12'h891

// ----------------------------------------------------------------
// Control field positions and masks
// ----------------------------------------------------------------
`define DACC_BIT_EN 7
`define DACC_BIT_RANGE 6
`define DACC_OE_HI 5
`define DACC_OE_LO 4
`define DACC_UPSEL_HI 3
`define DACC_UPSEL_LO 2
`define DACC_BIT_LOSEL 0
`define DACC_MASK_BUF 8'hFD
`define DACC_MASK_NOBUF 8'h8D
`define DACC_OE_PIN1 2'h1
`define DACC_OE_PIN2 2'h2

// ----------------------------------------------------------------
// Reset values and automatic range threshold
// ----------------------------------------------------------------
`define DACC_CTRL_RST 8'h00
`define DACC_DATA_RST 8'h00
`define DACC_AUTO_THRESH 8'h80

`endif

// [logic/dacc_pkg.sv]
// Purpose: Types shared by the converter control modules
// Assumes: Nothing beyond the language
// Notes: Numbers live in dacc_cfg.svh; only types here
package dacc_pkg;

	// Upper reference source encoding
	typedef enum logic [1:0]
	{
		DACC_UP_SUPPLY = 2'h0,
		DACC_UP_EXTREF = 2'h1,
		DACC_UP_FIXBUF2 = 2'h2,
		DACC_UP_AMPOUT = 2'h3
	} dacc_upref_t;

	// Lower reference source encoding
	typedef enum logic
	{
		DACC_LO_GROUND = 1'b0,
		DACC_LO_EXTREF = 1'b1
	} dacc_loref_t;

	// Buffer range choice
	typedef enum logic
	{
		DACC_RANGE_LOW = 1'b0,
		DACC_RANGE_HIGH = 1'b1
	} dacc_range_t;

endpackage : dacc_pkg

// [logic/dacc_channel.sv]
// Purpose: One converter instance: control and code registers, ladder tap, reference enable
// Assumes: Write strobes already decoded by the parent on the same clock
// Notes: Only the device reset clears state; wake events leave it alone
`include "dacc_cfg.svh"

module dacc_channel #(
	parameter bit HAS_BUF = 1'b1,
	parameter int CODE_W = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sleep,
	input wire logic ctrl_wr,
	input wire logic data_wr,
	input wire logic [7:0] wdata,
	output logic [7:0] ctrl_q,
	output logic [CODE_W-1:0] data_q,
	output logic [CODE_W-1:0] tap_q,
	output logic ref_en_q
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (CODE_W < 1 || CODE_W > 8)
	begin : g_bad_width
		$error("dacc_channel: CODE_W must be 1 to 8");
	end

	localparam logic [7:0] CtrlMask = HAS_BUF ? `DACC_MASK_BUF : `DACC_MASK_NOBUF;

	// Control register; unused bits held at zero so they read back as zero
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl_q <= `DACC_CTRL_RST;
		else if (ctrl_wr)
			ctrl_q <= wdata & CtrlMask;
	end

	// Code register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			data_q <= CODE_W'(`DACC_DATA_RST);
		else if (data_wr)
			data_q <= wdata[CODE_W-1:0];
	end

	// Ladder tap follows the code one clock later, parked at zero while off
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			tap_q <= '0;
		else if (ctrl_q[`DACC_BIT_EN])
			tap_q <= data_q;
		else
			tap_q <= '0;
	end

	// Reference powered only while enabled and awake, back on after wake
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ref_en_q <= 1'b0;
		else
			ref_en_q <= ctrl_q[`DACC_BIT_EN] & ~sleep;
	end

endmodule : dacc_channel

// [logic/dacc_range.sv]
// Purpose: Buffer range decision, software or automatic from the code
// Assumes: Config bit already synchronised; code is the live code register
// Notes: Automatic mode picks high range at or above the threshold
`include "dacc_cfg.svh"

module dacc_range #(
	parameter int CODE_W = 8,
	parameter logic [7:0] THRESH = `DACC_AUTO_THRESH
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic auto_range_cfg_n,
	input wire logic soft_range,
	input wire logic [CODE_W-1:0] code,
	output dacc_pkg::dacc_range_t range_q
);

	if (CODE_W < 1 || CODE_W > 8)
	begin : g_bad_width
		$error("dacc_range: CODE_W must be 1 to 8");
	end

	// Compare in the top bits so a narrower code scales the same threshold
	logic auto_high;
	assign auto_high = code >= THRESH[7 -: CODE_W];

	// Config one means software decides, zero means hardware decides
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			range_q <= dacc_pkg::DACC_RANGE_LOW;
		else if (auto_range_cfg_n)
			range_q <= dacc_pkg::dacc_range_t'(soft_range);
		else
			range_q <= dacc_pkg::dacc_range_t'(auto_high);
	end

endmodule : dacc_range

// [verification/dacc_control_bench.sv]
// Purpose: Self-checking bench for the two-converter control block
// Assumes: Register port with one-cycle strobes, read data one cycle after the read strobe
// Notes: Ordinary cases are table rows; reset, timing, sleep and odd addresses follow by hand
`include "dacc_cfg.svh"

module dacc_control_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [7:0] ctrl;
		logic [7:0] code;
		logic cfg_n;
		logic [1:0] pins;
		logic range;
	} dacc_row_t;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sleep = 1'b0;
	logic auto_range_cfg_n = 1'b1;
	logic [`DACC_ADDR_W-1:0] addr = 12'h000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata, level_code1, level_code2;
	logic conv1_en, conv2_en, ref1_en, ref2_en, buffer_en;
	logic [1:0] buffered_out_pins;
	dacc_pkg::dacc_upref_t upper_ref_select1, upper_ref_select2;
	dacc_pkg::dacc_loref_t lower_ref_select1, lower_ref_select2;
	dacc_pkg::dacc_range_t buffer_range_select;
	int miscompares = 0;
	int samples_checked = 0;
	dacc_row_t rows [7];

	// 50 MHz clock
	always #10 clk = ~clk;

	dacc_control dut (
		.clk(clk), .rst(rst), .sleep(sleep), .auto_range_cfg_n(auto_range_cfg_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.conv1_en(conv1_en), .conv2_en(conv2_en), .ref1_en(ref1_en), .ref2_en(ref2_en),
		.level_code1(level_code1), .level_code2(level_code2),
		.upper_ref_select1(upper_ref_select1), .lower_ref_select1(lower_ref_select1),
		.upper_ref_select2(upper_ref_select2), .lower_ref_select2(lower_ref_select2),
		.buffer_range_select(buffer_range_select), .buffer_en(buffer_en),
		.buffered_out_pins(buffered_out_pins)
	);

	// ----------------------------------------------------------------
	// Bus, compare and report tasks
	// ----------------------------------------------------------------
	// Four-state compare so an unknown never passes
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// Strobe is dropped at the sampling edge, so the next call starts one edge later
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data stands only in the cycle after the strobe, zero in the one after
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp, what);
		@(posedge clk);
		#1;
		chk(rdata, 8'h00, "rdata idle");
	endtask : rd_chk

	// Covers the config synchroniser plus the registered pin and reference stages
	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask : settle

	task automatic chk_cleared;
		#1;
		chk({conv1_en, conv2_en, ref1_en, ref2_en, buffer_en, buffered_out_pins,
			buffer_range_select}, 8'h00, "cleared flags");
		chk(level_code1, 8'h00, "cleared level1");
		chk(level_code2, 8'h00, "cleared level2");
		chk({2'h0, upper_ref_select1, lower_ref_select1, upper_ref_select2, lower_ref_select2},
			8'h00, "cleared selects");
		rd_chk(`DACC_OFS_CTRL1, `DACC_CTRL_RST, "ctrl1 reset");
		rd_chk(`DACC_OFS_DATA1, `DACC_DATA_RST, "data1 reset");
		rd_chk(`DACC_OFS_CTRL2, `DACC_CTRL_RST, "ctrl2 reset");
		rd_chk(`DACC_OFS_DATA2, `DACC_DATA_RST, "data2 reset");
	endtask : chk_cleared

	task automatic results;
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results

	// Hang guard; expiry counts as a mismatch
	initial
	begin
		#2000000;
		miscompares++;
		$display("MISMATCH at %0t: run did not finish", $time);
		results();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		// ctrl, code, cfg_n, expected pins, expected range
		rows = '{'{8'h90, 8'h55, 1'b1, 2'h1, 1'b0}, '{8'hE4, 8'h80, 1'b1, 2'h2, 1'b1},
			'{8'hB8, 8'hFF, 1'b1, 2'h0, 1'b0}, '{8'h8D, 8'h7F, 1'b0, 2'h0, 1'b0},
			'{8'h81, 8'h80, 1'b0, 2'h0, 1'b1}, '{8'hCD, 8'h7F, 1'b0, 2'h0, 1'b0},
			'{8'h10, 8'hA5, 1'b1, 2'h0, 1'b0}};
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		chk_cleared();
		$display("Reset state test done");

		foreach (rows[i])
		begin
			wr_reg(`DACC_OFS_CTRL1, rows[i].ctrl);
			wr_reg(`DACC_OFS_DATA1, rows[i].code);
			auto_range_cfg_n <= rows[i].cfg_n;
			settle();
			chk({5'h00, conv1_en, ref1_en, buffer_en}, {5'h00, {3{rows[i].ctrl[7]}}}, "enables");
			chk({6'h00, buffered_out_pins}, {6'h00, rows[i].pins}, "pins");
			chk({4'h0, upper_ref_select1, 1'b0, lower_ref_select1},
				{4'h0, rows[i].ctrl[3:2], 1'b0, rows[i].ctrl[0]}, "ref selects");
			chk(level_code1, rows[i].ctrl[7] ? rows[i].code : 8'h00, "level1");
			chk({7'h00, buffer_range_select}, {7'h00, rows[i].range}, "range");
			rd_chk(`DACC_OFS_CTRL1, rows[i].ctrl & `DACC_MASK_BUF, "ctrl1 readback");
			rd_chk(`DACC_OFS_DATA1, rows[i].code, "data1 readback");
			$display("Row %0d done", i);
		end

		// Code write reaches tap and automatic range one clock after the write
		wr_reg(`DACC_OFS_CTRL1, 8'h80);
		auto_range_cfg_n <= 1'b0;
		wr_reg(`DACC_OFS_DATA1, 8'h7F);
		settle();
		wr_reg(`DACC_OFS_DATA1, 8'h80);
		#1;
		chk(level_code1, 8'h7F, "level before update");
		chk({7'h00, buffer_range_select}, 8'h00, "range before update");
		@(posedge clk);
		#1;
		chk(level_code1, 8'h80, "level after update");
		chk({7'h00, buffer_range_select}, 8'h01, "range after update");
		$display("Update timing test done");

		// Second converter: no buffer bits, internal output only
		wr_reg(`DACC_OFS_CTRL2, 8'hFD);
		wr_reg(`DACC_OFS_DATA2, 8'h42);
		settle();
		chk({6'h00, conv2_en, ref2_en}, 8'h03, "conv2 enables");
		chk({4'h0, upper_ref_select2, 1'b0, lower_ref_select2}, 8'h0D, "conv2 selects");
		chk(level_code2, 8'h42, "level2");
		chk({6'h00, buffered_out_pins}, 8'h00, "pins untouched by conv2");
		rd_chk(`DACC_OFS_CTRL2, 8'hFD & `DACC_MASK_NOBUF, "ctrl2 readback");
		rd_chk(`DACC_OFS_DATA2, 8'h42, "data2 readback");
		$display("Second converter test done");

		// Unmapped offsets hold nothing
		wr_reg(12'h88E, 8'hFF);
		rd_chk(12'h88E, 8'h00, "unmapped read");
		rd_chk(12'h88F, 8'h00, "unmapped read");
		$display("Unmapped test done");

		// Sleep drops references and pins but keeps registers
		wr_reg(`DACC_OFS_CTRL1, 8'h90);
		@(posedge clk);
		sleep <= 1'b1;
		settle();
		chk({4'h0, conv1_en, ref1_en, conv2_en, ref2_en}, 8'h0A, "sleep refs");
		chk({5'h00, buffer_en, buffered_out_pins}, 8'h00, "sleep pins");
		rd_chk(`DACC_OFS_CTRL1, 8'h90, "ctrl1 kept");
		rd_chk(`DACC_OFS_DATA2, 8'h42, "data2 kept");
		@(posedge clk);
		sleep <= 1'b0;
		settle();
		chk({4'h0, ref1_en, ref2_en, buffered_out_pins}, 8'h0D, "wake refs");
		chk(level_code1, 8'h80, "wake level");
		$display("Sleep test done");

		// Reset in mid-run clears everything at once
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk({conv1_en, ref1_en, buffer_en, buffered_out_pins, conv2_en, ref2_en,
			buffer_range_select}, 8'h00, "reset in run");
		chk(level_code1, 8'h00, "reset level");
		@(posedge clk);
		rst <= 1'b0;
		chk_cleared();
		$display("Mid-run reset test done");
		results();
	end

endmodule : dacc_control_bench
